// ===== inc/slls_pkg.sv
// Shared constants and types for the serial loader link front end
package slls_pkg;
  localparam logic [7:0] SLLS_SYNC = 8'h55;
  localparam logic [7:0] SLLS_ACK = 8'hcc;
  localparam logic [7:0] SLLS_NAK = 8'h33;
  localparam int SLLS_SYNC_BITS = 20;
  localparam int SLLS_BAUD_RATIO = 32;
  localparam int SLLS_SCLK_RATIO = 12;
  localparam int SLLS_DIV_W = 16;
  localparam logic [3:0] SLLS_MEAS_FALLS = 4'h8;
  localparam int SLLS_MEAS_SHIFT = 4;
  localparam int SLLS_MEAS_ROUND = 9;
  localparam logic [3:0] SLLS_UART_FRAME = 4'ha;
  localparam logic [3:0] SLLS_UART_STOP = 4'h9;
  localparam logic [2:0] SLLS_SPI_LAST = 3'h7;
  localparam logic [3:0] SLLS_SPI_TRAIL = 4'h8;
  localparam logic [3:0] SLLS_SPI_GAP = 4'h9;
  typedef enum logic [1:0] {PORT_NONE, PORT_UART, PORT_SPI} slls_port_e;
endpackage : slls_pkg

// ===== inc/slls_link_if.sv
// Link wires between host end and loader device end
`timescale 1ns/1ps
interface slls_link_if;
  logic uart_h2d;
  logic uart_d2h;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;
  // Pull-up while the device is not driving
  assign miso = miso_oe ? miso_out : 1'b1;
  modport device (input uart_h2d, input sclk, input cs_n, input mosi,
    output uart_d2h, output miso_out, output miso_oe);
  modport host (output uart_h2d, output sclk, output cs_n, output mosi,
    input uart_d2h, input miso);
endinterface : slls_link_if

// ===== design/slls_uart.sv
// Byte UART, 8 data bits, no parity, one stop bit, runtime bit length
`timescale 1ns/1ps
module slls_uart #(
  parameter int DIV_W = slls_pkg::SLLS_DIV_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [DIV_W-1:0] bit_cycles,
  input wire logic rx_en,
  input wire logic rx,
  output logic rx_line,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_line
);
  import slls_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic [DIV_W-1:0] tcnt;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic [DIV_W-1:0] rcnt;
    logic [3:0] rbit;
    logic rbusy;
    logic [7:0] rsh;
    logic [7:0] rdata;
    logic rvalid;
  } slls_uart_s;
  slls_uart_s q;
  slls_uart_s n;
  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = q;
    n.s1 = rx;
    n.s2 = q.s1;
    n.rvalid = 1'b0;
    if (q.tbit == 4'h0)
    begin
      if (tx_valid)
      begin
        n.tsh = {1'b1, tx_data, 1'b0};
        n.tbit = SLLS_UART_FRAME;
        n.tcnt = bit_cycles - 1'b1;
      end
    end
    else if (q.tcnt == '0)
    begin
      n.tsh = {1'b1, q.tsh[9:1]};
      n.tbit = q.tbit - 4'h1;
      n.tcnt = bit_cycles - 1'b1;
    end
    else
      n.tcnt = q.tcnt - 1'b1;
    if (!rx_en)
      n.rbusy = 1'b0;
    else if (!q.rbusy)
    begin
      if (!q.s2)
      begin
        n.rbusy = 1'b1;
        n.rcnt = bit_cycles >> 1;
        n.rbit = 4'h0;
      end
    end
    else if (q.rcnt != '0)
      n.rcnt = q.rcnt - 1'b1;
    else
    begin
      n.rcnt = bit_cycles - 1'b1;
      if (q.rbit == SLLS_UART_STOP)
      begin
        n.rbusy = 1'b0;
        n.rvalid = q.s2;
        n.rdata = q.rsh;
      end
      else if (q.rbit == 4'h0 && q.s2)
        n.rbusy = 1'b0;
      else
      begin
        if (q.rbit != 4'h0)
          n.rsh = {q.s2, q.rsh[7:1]};
        n.rbit = q.rbit + 4'h1;
      end
    end
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= '{s1: 1'b1, s2: 1'b1, tsh: 10'h3ff, default: '0};
    else
      q <= n;
  end
  //////////////////////////////////////////////////////////////////////////////
  assign rx_line = q.s2;
  assign rx_data = q.rdata;
  assign rx_valid = q.rvalid;
  assign tx_ready = (q.tbit == 4'h0);
  assign tx_line = q.tsh[0];
endmodule : slls_uart

// ===== design/slls_device.sv
// Loader link front end: autobaud UART and slave SPI, first port locks
//
// Operation
// - UART characters are 8N1 only
// - Time two 0x55 characters, set divisor
// - Send 0xCC once baud is found
// - Host retries sync if no 0xCC
// - Host baud at most crystal over 32
// - First used port locks out other
// - SPI clock idles high, capture second edge
// - Host drives SPI clock; no detection
// - Host SPI clock at most crystal/12
// - Loader runs straight from crystal clock
// - Same byte format on both ports
// - Answer packets with 0xCC or 0x33
// - Leading zero bytes are discarded
`timescale 1ns/1ps
module slls_device #(
  parameter int DIV_W = slls_pkg::SLLS_DIV_W
) (
  input wire logic clk,
  input wire logic reset,
  slls_link_if.device link,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic skip_zero,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic resp_valid,
  input wire logic resp_good,
  output logic resp_ready,
  output slls_pkg::slls_port_e port_sel,
  output logic [DIV_W-1:0] baud_cycles
);
  import slls_pkg::*;
  localparam int CNT_W = DIV_W + 4;
  typedef enum logic [2:0] {AB_IDLE, AB_MEAS, AB_TAIL, AB_ACK, AB_DONE} slls_ab_e;
  typedef struct packed {
    slls_port_e port;
    slls_ab_e ab;
    logic [CNT_W-1:0] cnt;
    logic [3:0] falls;
    logic [DIV_W-1:0] bitc;
    logic prev;
    logic t1;
    logic t2;
    logic t3;
    logic [7:0] spi_out;
    logic [7:0] rdata;
    logic rvalid;
  } slls_dev_s;
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] shi;
    logic [7:0] sho;
    logic [7:0] word;
    logic tog;
  } slls_spi_s;
  slls_dev_s q;
  slls_dev_s n;
  slls_spi_s sq;
  slls_spi_s sn;
  logic rx_line;
  logic [7:0] urx_data;
  logic urx_valid;
  logic utx_ready;
  logic utx_valid;
  logic [7:0] utx_data;
  logic [7:0] out_byte;
  logic fall;
  logic fdone;
  logic spi_take;
  logic take;
  //////////////////////////////////////////////////////////////////////////////
  // UART engine on the crystal clock, bit length from the autobaud result
  slls_uart #(.DIV_W(DIV_W)) u_uart (
    .clk(clk),
    .reset(reset),
    .bit_cycles(q.bitc),
    .rx_en(q.port == PORT_UART),
    .rx(link.uart_h2d),
    .rx_line(rx_line),
    .rx_data(urx_data),
    .rx_valid(urx_valid),
    .tx_data(utx_data),
    .tx_valid(utx_valid),
    .tx_ready(utx_ready),
    .tx_line(link.uart_d2h)
  );
  //////////////////////////////////////////////////////////////////////////////
  // Next outgoing byte: answer first, then user data
  always_comb
  begin
    if (resp_valid)
      out_byte = resp_good ? SLLS_ACK : SLLS_NAK;
    else
      out_byte = tx_data;
  end
  assign fall = q.prev & ~rx_line;
  assign fdone = q.t2 ^ q.t3;
  // Frames are ignored once the UART has won or while autobaud runs
  assign spi_take = fdone && q.port != PORT_UART && q.ab == AB_IDLE;
  assign utx_valid = (q.ab == AB_ACK) ||
    (q.port == PORT_UART && q.ab == AB_DONE && (resp_valid || tx_valid));
  assign utx_data = (q.ab == AB_ACK) ? SLLS_ACK : out_byte;
  assign take = (q.port == PORT_UART) ? (utx_ready && q.ab == AB_DONE) : spi_take;
  assign resp_ready = take && resp_valid;
  assign tx_ready = take && !resp_valid;
  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [DIV_W-1:0] meas;
    logic [7:0] src_b;
    logic src_v;
    meas = DIV_W'((q.cnt + CNT_W'(SLLS_MEAS_ROUND)) >> SLLS_MEAS_SHIFT);
    src_b = 8'h00;
    src_v = 1'b0;
    n = q;
    n.prev = rx_line;
    n.t1 = sq.tog;
    n.t2 = q.t1;
    n.t3 = q.t2;
    n.rvalid = 1'b0;
    case (q.ab)
      AB_IDLE:
      begin
        if (fall && q.port == PORT_NONE)
        begin
          n.ab = AB_MEAS;
          n.cnt = '0;
          n.falls = 4'h1;
        end
      end
      AB_MEAS:
      begin
        n.cnt = q.cnt + 1'b1;
        if (&q.cnt)
          n.ab = AB_IDLE;
        else if (fall)
        begin
          n.falls = q.falls + 4'h1;
          // Ninth fall is sixteen bit times after the first
          if (q.falls == SLLS_MEAS_FALLS)
          begin
            n.bitc = meas;
            n.cnt = '0;
            // Too fast to sample reliably: wait for the next pattern
            n.ab = (meas < DIV_W'(SLLS_BAUD_RATIO)) ? AB_IDLE : AB_TAIL;
          end
        end
      end
      AB_TAIL:
      begin
        // Let the last four bits of the pattern pass before answering
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'({q.bitc, 2'b00}))
          n.ab = AB_ACK;
      end
      AB_ACK:
      begin
        if (utx_ready)
        begin
          n.ab = AB_DONE;
          n.port = PORT_UART;
        end
      end
      AB_DONE:
      begin
        src_v = urx_valid;
        src_b = urx_data;
      end
      default:
        n.ab = AB_IDLE;
    endcase
    if (spi_take)
    begin
      n.port = PORT_SPI;
      src_v = 1'b1;
      src_b = sq.word;
      // Zero padding when nothing is queued
      n.spi_out = (resp_valid || tx_valid) ? out_byte : 8'h00;
    end
    if (src_v)
    begin
      n.rdata = src_b;
      n.rvalid = !(skip_zero && src_b == 8'h00);
    end
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= '{port: PORT_NONE, ab: AB_IDLE, prev: 1'b1, default: '0};
    else
      q <= n;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Link clock side. The word and spi_out stay stable between frames, so
  // they cross as held data under the toggle handshake.
  always_comb
  begin
    sn = sq;
    if (!link.cs_n)
    begin
      sn.shi = {sq.shi[6:0], link.mosi};
      sn.sho = (sq.cnt == 3'h0) ? {q.spi_out[6:0], 1'b0} : {sq.sho[6:0], 1'b0};
      sn.cnt = sq.cnt + 3'h1;
      if (sq.cnt == SLLS_SPI_LAST)
      begin
        sn.word = {sq.shi[6:0], link.mosi};
        sn.tog = ~sq.tog;
      end
    end
  end
  always_ff @(posedge link.sclk or posedge reset)
  begin
    if (reset)
      sq <= '0;
    else
      sq <= sn;
  end
  // MSB first; new bit appears right after the capturing edge
  assign link.miso_out = (sq.cnt == 3'h0) ? q.spi_out[7] : sq.sho[7];
  assign link.miso_oe = !link.cs_n && q.port != PORT_UART;
  //////////////////////////////////////////////////////////////////////////////
  assign rx_data = q.rdata;
  assign rx_valid = q.rvalid;
  assign port_sel = q.port;
  assign baud_cycles = q.bitc;
endmodule : slls_device

// ===== design/slls_host.sv
// Host end: UART sync and retry, or SPI master with divided clock
`timescale 1ns/1ps
module slls_host #(
  parameter int BAUD_CYCLES = slls_pkg::SLLS_BAUD_RATIO,
  parameter int SCLK_DIV = slls_pkg::SLLS_SCLK_RATIO
) (
  input wire logic clk,
  input wire logic reset,
  slls_link_if.host link,
  input wire logic use_spi,
  input wire logic start,
  output logic link_up,
  input wire logic skip_zero,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  import slls_pkg::*;
  localparam int DIV_W = SLLS_DIV_W;
  localparam int WAIT_CYCLES = 2 * SLLS_SYNC_BITS * BAUD_CYCLES;
  localparam int HALF = SCLK_DIV / 2;
  typedef enum logic [2:0] {H_IDLE, H_SYNC1, H_SYNC2, H_WAIT, H_UP} slls_hst_e;
  typedef struct packed {
    slls_hst_e st;
    logic [31:0] tmo;
    logic busy;
    logic [15:0] scnt;
    logic [3:0] sbit;
    logic sclk;
    logic cs_n;
    logic [7:0] sho;
    logic [7:0] shi;
    logic ms1;
    logic ms2;
    logic [7:0] rdata;
    logic rvalid;
  } slls_hst_s;
  slls_hst_s q;
  slls_hst_s n;
  logic [7:0] urx_data;
  logic urx_valid;
  logic utx_ready;
  logic utx_valid;
  logic [7:0] utx_data;
  //////////////////////////////////////////////////////////////////////////////
  slls_uart #(.DIV_W(DIV_W)) u_uart (
    .clk(clk),
    .reset(reset),
    .bit_cycles(DIV_W'(BAUD_CYCLES)),
    .rx_en(1'b1),
    .rx(link.uart_d2h),
    .rx_line(),
    .rx_data(urx_data),
    .rx_valid(urx_valid),
    .tx_data(utx_data),
    .tx_valid(utx_valid),
    .tx_ready(utx_ready),
    .tx_line(link.uart_h2d)
  );
  assign utx_valid = (q.st == H_SYNC1) || (q.st == H_SYNC2) || (q.st == H_UP && tx_valid);
  assign utx_data = (q.st == H_UP) ? tx_data : SLLS_SYNC;
  assign tx_ready = use_spi ? !q.busy : (utx_ready && q.st == H_UP);
  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = q;
    n.ms1 = link.miso;
    n.ms2 = q.ms1;
    n.rvalid = 1'b0;
    case (q.st)
      H_IDLE:
        if (start && !use_spi)
          n.st = H_SYNC1;
      H_SYNC1:
        if (utx_ready)
          n.st = H_SYNC2;
      H_SYNC2:
        if (utx_ready)
        begin
          n.st = H_WAIT;
          n.tmo = 32'(WAIT_CYCLES);
        end
      H_WAIT:
      begin
        n.tmo = q.tmo - 32'h1;
        if (urx_valid && urx_data == SLLS_ACK)
          n.st = H_UP;
        else if (q.tmo == 32'h0)
          n.st = H_SYNC1;
      end
      H_UP:
        if (urx_valid)
        begin
          n.rdata = urx_data;
          n.rvalid = !(skip_zero && urx_data == 8'h00);
        end
      default:
        n.st = H_IDLE;
    endcase
    if (!q.busy)
    begin
      if (use_spi && tx_valid)
      begin
        n.busy = 1'b1;
        n.cs_n = 1'b0;
        n.sho = tx_data;
        n.sbit = 4'h0;
        n.scnt = 16'(HALF - 1);
      end
    end
    else if (q.scnt != 16'h0)
      n.scnt = q.scnt - 16'h1;
    else
    begin
      n.scnt = 16'(HALF - 1);
      if (q.sbit == SLLS_SPI_TRAIL)
      begin
        n.cs_n = 1'b1;
        n.sbit = SLLS_SPI_GAP;
      end
      else if (q.sbit == SLLS_SPI_GAP)
      begin
        n.busy = 1'b0;
        n.rdata = q.shi;
        n.rvalid = !(skip_zero && q.shi == 8'h00);
      end
      else if (q.sclk)
      begin
        n.sclk = 1'b0;
        if (q.sbit != 4'h0)
          n.sho = {q.sho[6:0], 1'b0};
      end
      else
      begin
        n.sclk = 1'b1;
        // Synced sample still reflects the low phase level
        n.shi = {q.shi[6:0], q.ms2};
        n.sbit = q.sbit + 4'h1;
      end
    end
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= '{st: H_IDLE, sclk: 1'b1, cs_n: 1'b1, ms1: 1'b1, ms2: 1'b1, default: '0};
    else
      q <= n;
  end
  //////////////////////////////////////////////////////////////////////////////
  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.mosi = q.sho[7];
  assign link_up = use_spi || q.st == H_UP;
  assign rx_data = q.rdata;
  assign rx_valid = q.rvalid;
endmodule : slls_host

// ===== verif/slls_link_chk.sv
// Concurrent checks on the link wires between host and device ends
`timescale 1ns/1ps
module slls_link_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic uart_h2d,
  input wire logic uart_d2h,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  logic sclk_q;
  logic [3:0] rises;
  logic [1:0] line;
  logic [1:0] prev;
  logic [9:0] run [2];
  assign line = {uart_d2h, uart_h2d};
  ////////////////////////////////////////
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_q <= 1'b1;
      rises <= 4'h0;
      prev <= 2'h3;
      run <= '{10'h000, 10'h000};
    end
    else
    begin
      sclk_q <= sclk;
      rises <= cs_n ? 4'h0 : rises + 4'(sclk & ~sclk_q);
      prev <= line;
      // Saturates so long idle stretches never wrap into a false count
      for (int i = 0; i < 2; i++)
        run[i] <= (line[i] != prev[i]) ? 10'h001 : run[i] + 10'(run[i] != 10'h3ff);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("sclk low outside a frame");
  chk_sclk_low_span: assert property ($fell(sclk) |-> !sclk [*6] ##1 sclk)
    else $error("sclk low phase not six clocks");
  chk_frame_bit_count: assert property ($rose(cs_n) |-> rises == 4'h8)
    else $error("frame without eight sclk rises");
  chk_frame_gap: assert property ($rose(cs_n) |-> cs_n [*6])
    else $error("select gap too short");
  chk_mosi_hold: assert property
    (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  chk_miso_hold: assert property
    (miso_oe && !sclk && !$past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk low");
  chk_miso_release: assert property (cs_n && $past(cs_n) |-> !miso_oe)
    else $error("miso driven while deselected");
  // Host runs 32 clk per bit; a low run is at most start plus 8 zeros
  chk_h2d_bit_time: assert property
    (line[0] && !prev[0] |-> run[0][4:0] == 5'h00 && run[0] <= 10'h120)
    else $error("host line low run not whole bits");
  chk_d2h_bit_time: assert property
    (line[1] && !prev[1] |-> run[1][4:0] == 5'h00 && run[1] <= 10'h120)
    else $error("device line low run not whole bits");
  cover property ($rose(cs_n));
  cover property (line[1] && !prev[1]);
  cover property (miso_oe && !sclk);
endmodule : slls_link_chk

// ===== verif/tb_serial_loader_link_setup.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
module tb_serial_loader_link_setup;
  import slls_pkg::*;
  typedef struct {int side; logic [7:0] val; logic [7:0] exp;} slls_row_s;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic use_spi = 1'b0;
  logic start = 1'b0;
  logic h_skip = 1'b0;
  logic d_skip = 1'b0;
  logic rg = 1'b0;
  logic [2:0] req = 3'h0;
  logic [7:0] h_txd = 8'h00;
  logic [7:0] d_txd = 8'h00;
  logic link_up, h_txr, h_rxv, d_txr, d_rxv, rr;
  logic [7:0] h_rxd, d_rxd;
  logic [5:0] hs;
  slls_port_e port_sel;
  logic [SLLS_DIV_W-1:0] baud_cycles;
  int error_cnt = 0;
  int samples_checked = 0;
  int d_rx_cnt = 0;
  int h2d_falls = 0;
  logic h2d_q = 1'b1;
  // Side 0 host to device, 1 device to host, 2 device response
  slls_row_s rows [7] = '{'{0, 8'h00, 8'h00}, '{0, 8'hff, 8'hff}, '{0, 8'h80, 8'h80},
    '{1, 8'h01, 8'h01}, '{1, 8'hfe, 8'hfe}, '{2, 8'h01, SLLS_ACK}, '{2, 8'h00, SLLS_NAK}};
  assign hs = {link_up, h_rxv, d_rxv, rr, d_txr, h_txr};
  always #50 clk = ~clk;
  always @(posedge clk) if (d_rxv === 1'b1) d_rx_cnt++;
  ////////////////////////////////////////
  slls_link_if link ();
  slls_host #(.BAUD_CYCLES(32), .SCLK_DIV(12)) u_slls_host (.clk(clk), .reset(reset),
    .link(link.host), .use_spi(use_spi), .start(start), .link_up(link_up),
    .skip_zero(h_skip), .tx_data(h_txd), .tx_valid(req[0]), .tx_ready(h_txr),
    .rx_data(h_rxd), .rx_valid(h_rxv));
  slls_device #(.DIV_W(SLLS_DIV_W)) u_slls_device (.clk(clk), .reset(reset),
    .link(link.device), .rx_data(d_rxd), .rx_valid(d_rxv), .skip_zero(d_skip),
    .tx_data(d_txd), .tx_valid(req[1]), .tx_ready(d_txr), .resp_valid(req[2]),
    .resp_good(rg), .resp_ready(rr), .port_sel(port_sel), .baud_cycles(baud_cycles));
  slls_link_chk u_slls_link_chk (.clk(clk), .reset(reset), .uart_h2d(link.uart_h2d),
    .uart_d2h(link.uart_d2h), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso_out(link.miso_out), .miso_oe(link.miso_oe), .miso(link.miso));
  // Start bits and zero bits on the host line, for the retry count
  always @(posedge clk) h2d_q <= link.uart_h2d;
  always @(posedge clk) if (h2d_q && !link.uart_h2d) h2d_falls++;
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (n < 4000 && hs[w] !== 1'b1);
    if (n >= 4000)
    begin
      error_cnt++;
      $display("[ERR] %0t handshake %0d timed out", $time, w);
    end
  endtask : wait_hi
  // Request held from a falling edge until ready is seen at a rising edge
  task automatic send(input int side, input logic [7:0] b);
    @(negedge clk);
    if (side == 0) h_txd = b;
    if (side == 1) d_txd = b;
    if (side == 2) rg = b[0];
    req[side] = 1'b1;
    wait_hi(side);
    @(negedge clk);
    req[side] = 1'b0;
  endtask : send
  task automatic get(input int w, output logic [7:0] d);
    wait_hi(w);
    d = (w == 3) ? d_rxd : h_rxd;
  endtask : get
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  ////////////////////////////////////////
  initial
  begin
    #5ms;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  initial
  begin
    logic [7:0] got;
    logic [7:0] seen [2];
    int n0;
    int f0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    chk(16'(port_sel), 16'(PORT_NONE));
    chk(baud_cycles, 16'h0000);
    chk({12'h000, link.sclk, link.cs_n, link.uart_h2d, link.uart_d2h}, 16'h000f);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wait_hi(5);
    chk(16'(port_sel), 16'(PORT_UART));
    chk(baud_cycles, 16'h0020);
    foreach (rows[i])
    begin
      send(rows[i].side, rows[i].val);
      get(rows[i].side == 0 ? 3 : 4, got);
      chk(got, rows[i].exp);
    end
    // SPI frames after UART lock must reach nobody; miso stays pulled up
    @(negedge clk);
    use_spi = 1'b1;
    n0 = d_rx_cnt;
    send(0, 8'h99);
    get(4, got);
    chk(got, 8'hff);
    chk(16'(d_rx_cnt - n0), 16'h0000);
    chk(16'(port_sel), 16'(PORT_UART));
    @(negedge clk);
    reset = 1'b1;
    h_skip = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    fork
      send(1, 8'h3c);
      send(0, 8'ha5);
      get(3, got);
    join
    chk(got, 8'ha5);
    chk(16'(port_sel), 16'(PORT_SPI));
    fork
      send(0, 8'h00);
      get(4, got);
    join
    chk(got, 8'h3c);
    @(negedge clk);
    d_skip = 1'b1;
    fork
      get(3, got);
      for (int i = 0; i < 2; i++) send(0, 8'h5a & {8{i[0]}});
    join
    chk(got, 8'h5a);
    fork
      send(2, 8'h00);
      send(1, 8'h77);
      for (int i = 0; i < 3; i++) send(0, 8'h00);
      for (int i = 0; i < 2; i++) get(4, seen[i]);
    join
    chk(seen[0], SLLS_NAK);
    chk(seen[1], 8'h77);
    // UART sync after SPI lock goes unanswered, so the host must retry.
    // Two sync bytes give ten falls; the retry after forty bit times
    // shows its start bit and first zero bit inside the window.
    @(negedge clk);
    use_spi = 1'b0;
    f0 = h2d_falls;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (1700) @(negedge clk);
    chk(16'(h2d_falls - f0), 16'h000c);
    chk(16'(link_up), 16'h0000);
    chk(16'(port_sel), 16'(PORT_SPI));
    chk(baud_cycles, 16'h0000);
    chk(16'(link.uart_d2h), 16'h0001);
    results();
  end
endmodule : tb_serial_loader_link_setup
